// *** hw/mst_pkg.sv ***
package mst_pkg;
	// Register indices; byte address is four times the index
	localparam logic [6:0] SYNC_DETECT_CONTROL_IDX = 7'h47;
	localparam logic [6:0] FREQ_OFFSET_ESTIMATE_IDX = 7'h48;
	localparam logic [6:0] MODEM_TEST_CONTROL_IDX = 7'h5b;
	localparam int ADDR_W = 9;

	// sync_detect_control fields
	localparam int THR_LSB = 0;
	localparam int THR_W = 5;
	localparam int STRICT_BIT = 5;
	localparam logic [7:0] SYNC_DETECT_CONTROL_RST = 8'h2e;
	localparam logic [7:0] SYNC_DETECT_CONTROL_WMASK = 8'h3f;
	localparam logic [7:0] FREQ_OFFSET_ESTIMATE_RST = 8'h00;

	// modem_test_control fields
	localparam int SNIFF_BIT = 2;
	localparam int PHASE_BIT = 1;
	localparam logic [7:0] MODEM_TEST_CONTROL_RST = 8'h08;
	localparam logic [7:0] MODEM_TEST_CONTROL_WMASK = 8'h0f;

	// Frequency step of one estimate count, in hertz
	localparam int FREQ_STEP_HZ = 7800;

	// Plain read-write tuning registers: index and reset value
	localparam int TUNE_N = 26;
	localparam logic [TUNE_N-1:0][6:0] TUNE_IDX = {
		7'h4a, 7'h4c, 7'h4e, 7'h4f, 7'h50, 7'h51, 7'h52, 7'h53, 7'h54,
		7'h55, 7'h56, 7'h57, 7'h58, 7'h5a, 7'h5c, 7'h5d, 7'h5e, 7'h5f,
		7'h60, 7'h61, 7'h7a, 7'h7c, 7'h7e, 7'h7e, 7'h7e, 7'h7e
	};
	localparam logic [TUNE_N-1:0][7:0] TUNE_RST = {
		8'h29, 8'h55, 8'h24, 8'h29, 8'h20, 8'h2a, 8'h5f, 8'h0e, 8'h00,
		8'h2e, 8'h66, 8'h0a, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h02, 8'h02
	};
	localparam int TUNE_USED = 23;
	localparam logic [6:0] UNUSED_SLOT_IDX = 7'h62;

	// Minimum zero symbols per preamble_zero_count code
	localparam logic [1:0] ZERO_CNT_RSVD = 2'h0;
	localparam logic [1:0] ZERO_CNT_MAX = 2'h3;

	typedef enum logic [2:0] {
		MST_SEARCH = 3'h1,
		MST_DELIM = 3'h2,
		MST_LOCKED = 3'h4
	} mst_state_t;
endpackage

// *** hw/mst_regs.sv ***
// Functional notes
// - Loose mode: one strong zero symbol suffices
// - Strict mode: both delimiter symbols also strong
// - Five-bit threshold, reset 0x0e, gates delimiter search
// - Signed eight-bit read-only offset estimate, reset zero
// - One estimate count equals 7800 Hz
// - Mode 0: estimate frozen from sync to frame end
// - Mode 1: estimate tracks while demodulator enabled
// - Sniffer enable resets to zero
// - Sniffer on: receive and transmit data on pins
// - Phase bit selects compliant or reversed modulation
// - Zero-count code sets needed zero symbols
// - Averaging mode: lock per frame or track
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module mst_regs (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic [mst_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic demod_enable_in,
	input wire logic [1:0] preamble_zero_count_in,
	input wire logic offset_averaging_select_in,
	input wire logic sym_valid_in,
	input wire logic sym_is_zero_in,
	input wire logic sym_is_delim_in,
	input wire logic [4:0] sym_corr_in,
	input wire logic frame_end_in,
	input wire logic freq_valid_in,
	input wire logic [7:0] freq_in,
	input wire logic rx_data_in,
	input wire logic tx_data_in,
	output logic sync_found_out,
	output logic sync_locked_out,
	output logic sniffer_enable_out,
	output logic sniff_rx_data_out,
	output logic sniff_tx_data_out,
	output logic modulation_reversed_out
);
	typedef struct packed {
		mst_pkg::mst_state_t state;
		logic [1:0] zero_cnt;
		logic zero_hit;
		logic delim_hit;
		logic [7:0] sync_ctrl;
		logic [7:0] freq;
		logic [7:0] test_ctrl;
		logic [mst_pkg::TUNE_N-1:0][7:0] tune;
		logic wait_n;
		logic waitreq;
		logic [31:0] rdata;
		logic sync_pulse;
		logic sniff_rx;
		logic sniff_tx;
		logic locked;
	} mst_regs_t;

	mst_regs_t r_q;
	mst_regs_t r_d;

	logic [6:0] idx;
	logic access;
	logic wr_go;
	logic above;
	logic [1:0] need;
	logic strict;
	logic [7:0] rd_val;

	// Register map by word index; byte address is four times it
	// 0x47 sync_detect_control: mixed, reset 0x2e
	// 0x48 freq_offset_estimate: read-only, reset 0x00
	// 0x4a rx_path_tuning: storage, reset 0x29
	// 0x4c synth_tuning: storage, reset 0x55
	// 0x4e synth_cal_tuning: storage, reset 0x24
	// 0x4f vco_tuning_a: storage, reset 0x29
	// 0x50 vco_tuning_b: storage, reset 0x20
	// 0x51 vco_tuning_c: storage, reset 0x2a
	// 0x52 gain_ctrl_tuning_a: storage, reset 0x5f
	// 0x53 gain_ctrl_tuning_b: storage, reset 0x0e
	// 0x54 lna_tuning: storage, reset 0x00
	// 0x55 gain_filter_tuning: storage, reset 0x2e
	// 0x56 converter_tuning_a: storage, reset 0x66
	// 0x57 converter_tuning_b: storage, reset 0x0a
	// 0x58 converter_tuning_c: storage, reset 0x05
	// 0x5a modem_tuning_a: storage, reset 0x05
	// 0x5b modem_test_control: mixed, reset 0x08
	// 0x5c dac_tuning_a: storage, reset 0x00
	// 0x5d dac_tuning_b: storage, reset 0x00
	// 0x5e analog_test_select: storage, reset 0x00
	// 0x5f dac_tuning_c: storage, reset 0x00
	// 0x60 powerdown_tuning_a: storage, reset 0x00
	// 0x61 powerdown_tuning_b: storage, reset 0x00
	// 0x62 unused_slot: reads zero, writes dropped
	// 0x7a processing_rom_selftest: storage, reset 0x00
	// 0x7c control_rom_selftest: storage, reset 0x00
	// 0x7e ram_selftest: storage, reset 0x02
	// Any other index, or a misaligned byte address, reads zero
	// Tuning storage drives nothing here; it only holds values

	// sync_detect_control fields
	// Bits 7:6 reserved, read zero
	// Bit 5 delimiter_match_strict, reset 1
	// Bits 4:0 correlator_threshold, reset 0x0e

	// modem_test_control fields
	// Bits 7:4 reserved, read zero
	// Bit 3 stored only, reset 1; software should leave it
	// Bit 2 sniffer_enable, reset 0
	// Bit 1 modulation phase, set reverses it
	// Bit 0 stored only, reset 0; software should leave it

	// Bus timing: request seen at edge 1 raises the ack flop
	// Waitrequest low for one cycle, read data already standing
	// Write lands at edge 2, where the master sees the ack
	// Hazard: a request held past edge 2 is answered twice
	// No response code; refused accesses still get an ack

	// Sync search walk
	// Search: count zero symbols, note any above threshold
	// Delimiter after enough zeros and one strong zero moves on
	// Second delimiter decides; strict mode needs both strong
	// Locked until frame end or demodulator off
	// Limitation: zero count saturates at three
	// Estimate follows freq_in while demodulator on, unless locked in freeze mode

	// Decode and handshake terms
	assign idx = avs_address_in[mst_pkg::ADDR_W-1:2];
	assign access = avs_read_in | avs_write_in;
	assign wr_go = avs_write_in & r_q.wait_n & avs_byteenable_in[0] & (avs_address_in[1:0] == 2'h0);
	assign above = sym_corr_in > r_q.sync_ctrl[mst_pkg::THR_LSB +: mst_pkg::THR_W];
	assign strict = r_q.sync_ctrl[mst_pkg::STRICT_BIT];
	// Reserved zero-count code treated as one symbol
	assign need = (preamble_zero_count_in == mst_pkg::ZERO_CNT_RSVD) ? 2'h1 : preamble_zero_count_in;

	// Read mux; unmapped and reserved locations read zero
	always_comb begin
		rd_val = 8'h00;
		if (avs_address_in[1:0] == 2'h0) begin
			if (idx == mst_pkg::SYNC_DETECT_CONTROL_IDX) begin
				rd_val = r_q.sync_ctrl & mst_pkg::SYNC_DETECT_CONTROL_WMASK;
			end else if (idx == mst_pkg::FREQ_OFFSET_ESTIMATE_IDX) begin
				rd_val = r_q.freq;
			end else if (idx == mst_pkg::MODEM_TEST_CONTROL_IDX) begin
				rd_val = r_q.test_ctrl & mst_pkg::MODEM_TEST_CONTROL_WMASK;
			end else begin
				for (int i = 0; i < mst_pkg::TUNE_USED; i++) begin
					if (idx == mst_pkg::TUNE_IDX[mst_pkg::TUNE_N-1-i]) begin
						rd_val = r_q.tune[mst_pkg::TUNE_N-1-i];
					end
				end
			end
		end
	end

	// Next-state logic
	always_comb begin
		r_d = r_q;
		r_d.sync_pulse = 1'b0;

		// Answer one cycle after the request appears, then release
		if (access && !r_q.wait_n) begin
			r_d.wait_n = 1'b1;
			r_d.rdata = {24'h000000, rd_val};
		end else begin
			r_d.wait_n = 1'b0;
		end

		// Writes land on the edge where waitrequest is seen low
		if (wr_go) begin
			if (idx == mst_pkg::SYNC_DETECT_CONTROL_IDX) begin
				r_d.sync_ctrl = avs_writedata_in[7:0] & mst_pkg::SYNC_DETECT_CONTROL_WMASK;
			end else if (idx == mst_pkg::MODEM_TEST_CONTROL_IDX) begin
				r_d.test_ctrl = avs_writedata_in[7:0] & mst_pkg::MODEM_TEST_CONTROL_WMASK;
			end else begin
				for (int i = 0; i < mst_pkg::TUNE_USED; i++) begin
					if (idx == mst_pkg::TUNE_IDX[mst_pkg::TUNE_N-1-i]) begin
						r_d.tune[mst_pkg::TUNE_N-1-i] = avs_writedata_in[7:0];
					end
				end
			end
		end

		// Sync search: preamble zeros, then two delimiter symbols
		case (r_q.state)
			mst_pkg::MST_SEARCH: begin
				if (sym_valid_in && sym_is_zero_in) begin
					if (r_q.zero_cnt != mst_pkg::ZERO_CNT_MAX) begin
						r_d.zero_cnt = r_q.zero_cnt + 2'h1;
					end
					r_d.zero_hit = r_q.zero_hit | above;
				end else if (sym_valid_in && sym_is_delim_in) begin
					if (r_q.zero_cnt >= need && r_q.zero_hit) begin
						r_d.state = mst_pkg::MST_DELIM;
						r_d.delim_hit = above;
					end else begin
						r_d.zero_cnt = 2'h0;
						r_d.zero_hit = 1'b0;
					end
				end else if (sym_valid_in) begin
					r_d.zero_cnt = 2'h0;
					r_d.zero_hit = 1'b0;
				end
			end
			mst_pkg::MST_DELIM: begin
				if (sym_valid_in) begin
					r_d.zero_cnt = 2'h0;
					r_d.zero_hit = 1'b0;
					if (sym_is_delim_in && (!strict || (r_q.delim_hit && above))) begin
						r_d.state = mst_pkg::MST_LOCKED;
						r_d.sync_pulse = 1'b1;
					end else begin
						r_d.state = mst_pkg::MST_SEARCH;
					end
				end
			end
			mst_pkg::MST_LOCKED: begin
				if (frame_end_in) begin
					r_d.state = mst_pkg::MST_SEARCH;
				end
			end
			default: begin
				r_d.state = mst_pkg::MST_SEARCH;
			end
		endcase
		if (!demod_enable_in) begin
			r_d.state = mst_pkg::MST_SEARCH;
			r_d.zero_cnt = 2'h0;
			r_d.zero_hit = 1'b0;
		end

		// Estimate frozen while locked unless tracking mode
		if (demod_enable_in && freq_valid_in) begin
			if (offset_averaging_select_in || r_q.state != mst_pkg::MST_LOCKED) begin
				r_d.freq = freq_in;
			end
		end

		// Sniffer taps are forced low when disabled
		r_d.sniff_rx = r_q.test_ctrl[mst_pkg::SNIFF_BIT] & rx_data_in;
		r_d.sniff_tx = r_q.test_ctrl[mst_pkg::SNIFF_BIT] & tx_data_in;

		// Registered copies, so no gate sits between flop and pin
		r_d.waitreq = !r_d.wait_n;
		r_d.locked = r_d.state == mst_pkg::MST_LOCKED;
	end

	// State register
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			r_q.state <= mst_pkg::MST_SEARCH;
			r_q.zero_cnt <= 2'h0;
			r_q.zero_hit <= 1'b0;
			r_q.delim_hit <= 1'b0;
			r_q.sync_ctrl <= mst_pkg::SYNC_DETECT_CONTROL_RST;
			r_q.freq <= mst_pkg::FREQ_OFFSET_ESTIMATE_RST;
			r_q.test_ctrl <= mst_pkg::MODEM_TEST_CONTROL_RST;
			r_q.tune <= mst_pkg::TUNE_RST;
			r_q.wait_n <= 1'b0;
			r_q.waitreq <= 1'b1;
			r_q.rdata <= 32'h00000000;
			r_q.sync_pulse <= 1'b0;
			r_q.sniff_rx <= 1'b0;
			r_q.sniff_tx <= 1'b0;
			r_q.locked <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs straight from flops
	assign avs_readdata_out = r_q.rdata;
	assign avs_waitrequest_out = r_q.waitreq;
	assign sync_found_out = r_q.sync_pulse;
	assign sync_locked_out = r_q.locked;
	assign sniffer_enable_out = r_q.test_ctrl[mst_pkg::SNIFF_BIT];
	assign sniff_rx_data_out = r_q.sniff_rx;
	assign sniff_tx_data_out = r_q.sniff_tx;
	assign modulation_reversed_out = r_q.test_ctrl[mst_pkg::PHASE_BIT];
endmodule
`default_nettype wire

// *** dv/mst_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module mst_chk (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic demod_enable_in,
	input wire logic sym_valid_in,
	input wire logic sym_is_delim_in,
	input wire logic rx_data_in,
	input wire logic tx_data_in,
	input wire logic sync_found_out,
	input wire logic sync_locked_out,
	input wire logic sniffer_enable_out,
	input wire logic sniff_rx_data_out,
	input wire logic sniff_tx_data_out
);
	// One clock domain, so clock and reset are shared
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	// Bus answers one cycle after a request and only for one cycle
	a_req_acked: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("request not answered");
	a_ack_single: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
		else $error("ack held too long");
	a_upper_zero: assert property (avs_readdata_out[31:8] == 24'h0)
		else $error("read data upper bits set");
	// Lock only follows an accepted delimiter symbol
	a_lock_cause: assert property ($rose(sync_locked_out) |->
		$past(sym_valid_in && sym_is_delim_in) && sync_found_out) else $error("bad lock");
	a_found_pulse: assert property (sync_found_out |=> !sync_found_out)
		else $error("found not a pulse");
	a_demod_off: assert property (!demod_enable_in |=> !sync_locked_out)
		else $error("locked while disabled");
	// Sniff outputs need the enable, now or a cycle ago
	a_sniff_rx: assert property (sniff_rx_data_out |-> $past(rx_data_in) &&
		(sniffer_enable_out || $past(sniffer_enable_out))) else $error("rx sniff leak");
	a_sniff_tx: assert property (sniff_tx_data_out |-> $past(tx_data_in) &&
		(sniffer_enable_out || $past(sniffer_enable_out))) else $error("tx sniff leak");
endmodule
bind mst_regs mst_chk u_chk (
	.clock_in(clock_in),
	.rst_b_in(rst_b_in),
	.avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out),
	.demod_enable_in(demod_enable_in),
	.sym_valid_in(sym_valid_in),
	.sym_is_delim_in(sym_is_delim_in),
	.rx_data_in(rx_data_in),
	.tx_data_in(tx_data_in),
	.sync_found_out(sync_found_out),
	.sync_locked_out(sync_locked_out),
	.sniffer_enable_out(sniffer_enable_out),
	.sniff_rx_data_out(sniff_rx_data_out),
	.sniff_tx_data_out(sniff_tx_data_out)
);
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clock_in = 1'h0, rst_b_in = 1'h0, avs_read_in = 1'h0, avs_write_in = 1'h0;
	logic [8:0] avs_address_in = 9'h0;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
	logic [3:0] avs_byteenable_in = 4'hf;
	logic demod_enable_in = 1'h1, offset_averaging_select_in = 1'h0, sym_valid_in = 1'h0;
	logic sym_is_zero_in = 1'h0, sym_is_delim_in = 1'h0, frame_end_in = 1'h0;
	logic freq_valid_in = 1'h0, rx_data_in = 1'h0, tx_data_in = 1'h0;
	logic [1:0] preamble_zero_count_in = 2'h1;
	logic [4:0] sym_corr_in = 5'h0;
	logic [7:0] freq_in = 8'h0, rd;
	logic avs_waitrequest_out, sync_found_out, sync_locked_out, sniffer_enable_out;
	logic sniff_rx_data_out, sniff_tx_data_out, modulation_reversed_out;
	int num_errors = 0, total_checks = 0;
	mst_regs u_dut (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.demod_enable_in(demod_enable_in),
		.preamble_zero_count_in(preamble_zero_count_in),
		.offset_averaging_select_in(offset_averaging_select_in),
		.sym_valid_in(sym_valid_in),
		.sym_is_zero_in(sym_is_zero_in),
		.sym_is_delim_in(sym_is_delim_in),
		.sym_corr_in(sym_corr_in),
		.frame_end_in(frame_end_in),
		.freq_valid_in(freq_valid_in),
		.freq_in(freq_in),
		.rx_data_in(rx_data_in),
		.tx_data_in(tx_data_in),
		.sync_found_out(sync_found_out),
		.sync_locked_out(sync_locked_out),
		.sniffer_enable_out(sniffer_enable_out),
		.sniff_rx_data_out(sniff_rx_data_out),
		.sniff_tx_data_out(sniff_tx_data_out),
		.modulation_reversed_out(modulation_reversed_out)
	);
	// 50 MHz core clock
	always #10 clock_in = ~clock_in;
	task summarize;
		if (num_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %0t seen %h want %h", $time, s, e);
		end
	endtask
	// Request held until waitrequest is seen low, bounded wait
	task bus(input logic w, input logic [6:0] i, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		avs_address_in <= {i, 2'h0};
		avs_read_in <= !w;
		avs_write_in <= w;
		avs_writedata_in <= {24'h0, d};
		do begin
			@(posedge clock_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		rd = avs_readdata_out[7:0];
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			summarize();
		end
	endtask
	task rdc(input logic [6:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h0);
		chk(rd, e);
	endtask
	task sym(input logic z, input logic d, input logic [4:0] c);
		@(posedge clock_in);
		sym_valid_in <= 1'b1;
		sym_is_zero_in <= z;
		sym_is_delim_in <= d;
		sym_corr_in <= c;
	endtask
	// Weak zeros, one strong zero, strong then weak delimiter; watch for lock
	task frame(input logic [7:0] cfg, input logic [1:0] nz, input logic e);
		logic s;
		s = 1'b0;
		bus(1'b1, 7'h47, cfg);
		repeat (nz - 1) sym(1'b1, 1'b0, 5'h00);
		sym(1'b1, 1'b0, 5'h15);
		sym(1'b0, 1'b1, 5'h15);
		sym(1'b0, 1'b1, 5'h00);
		repeat (6) begin
			@(posedge clock_in);
			sym_valid_in <= 1'b0;
			if (sync_found_out === 1'b1) s = 1'b1;
		end
		chk(s, e);
		chk(sync_locked_out, e);
	endtask
	// One-cycle frame end pulse
	task fend;
		@(posedge clock_in);
		frame_end_in <= 1'b1;
		@(posedge clock_in);
		frame_end_in <= 1'b0;
	endtask
	task fq(input logic [7:0] d);
		@(posedge clock_in);
		freq_valid_in <= 1'b1;
		freq_in <= d;
		@(posedge clock_in);
		freq_valid_in <= 1'b0;
	endtask
	initial begin
		repeat (4) @(posedge clock_in);
		rst_b_in <= 1'b1;
		chk(sniffer_enable_out, 1'b0);
		chk(modulation_reversed_out, 1'b0);
		chk({avs_waitrequest_out, sync_locked_out, sync_found_out}, 3'h4);
		rdc(7'h47, 8'h2e);
		rdc(7'h48, 8'h00);
		rdc(7'h5b, 8'h08);
		// Tuning registers are only read, never written
		for (int i = 0; i < mst_pkg::TUNE_USED; i++) begin
			rdc(mst_pkg::TUNE_IDX[mst_pkg::TUNE_N-1-i], mst_pkg::TUNE_RST[mst_pkg::TUNE_N-1-i]);
		end
		bus(1'b1, 7'h47, 8'hff);
		rdc(7'h47, 8'h3f);
		bus(1'b1, 7'h62, 8'hff);
		rdc(7'h62, 8'h00);
		bus(1'b1, 7'h48, 8'hff);
		rdc(7'h48, 8'h00);
		bus(1'b1, 7'h5b, 8'h06);
		rx_data_in <= 1'b1;
		tx_data_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		chk({sniffer_enable_out, modulation_reversed_out}, 2'h3);
		chk({sniff_rx_data_out, sniff_tx_data_out}, 2'h3);
		// Strict rejects the weak delimiter, loose accepts it
		frame(8'h34, 2'h1, 1'b0);
		fq(8'h80);
		rdc(7'h48, 8'h80);
		// Advised receive setup: strict off, threshold 0x14
		frame(8'h14, 2'h1, 1'b1);
		fq(8'h12);
		rdc(7'h48, 8'h80);
		fend();
		fq(8'h12);
		rdc(7'h48, 8'h12);
		offset_averaging_select_in <= 1'b1;
		frame(8'h14, 2'h1, 1'b1);
		fq(8'h7f);
		rdc(7'h48, 8'h7f);
		fend();
		// Zero-count codes two and three, then reserved taken as one
		preamble_zero_count_in <= 2'h2;
		frame(8'h14, 2'h1, 1'b0);
		frame(8'h14, 2'h2, 1'b1);
		fend();
		preamble_zero_count_in <= 2'h3;
		frame(8'h14, 2'h2, 1'b0);
		preamble_zero_count_in <= 2'h0;
		frame(8'h14, 2'h1, 1'b1);
		// Demodulator off drops lock and stops the estimate
		demod_enable_in <= 1'b0;
		fq(8'h33);
		chk(sync_locked_out, 1'b0);
		demod_enable_in <= 1'b1;
		rdc(7'h48, 8'h7f);
		// Mid-run reset brings controls and estimate back
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		rst_b_in <= 1'b1;
		chk({sniffer_enable_out, modulation_reversed_out, sync_locked_out}, 3'h0);
		rdc(7'h5b, 8'h08);
		rdc(7'h48, 8'h00);
		rdc(7'h47, 8'h2e);
		summarize();
	end
endmodule
`default_nettype wire
